/* src/tsf_framer.sv */
// TDM serial audio framer: register port, slot timing, word shift in and out
`timescale 1ns/10ps
module tsf_framer
	import tsf_pkg::*;
#(
	parameter int NCH = 16
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic [31:0]       bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic [31:0]            bus_rdata,
	input  wire logic              bit_clk,
	input  wire logic              frame_clk,
	input  wire logic              data_in,
	output logic                   data_out
);
	if (NCH != 8 && NCH != 16) begin : g_chk
		$error("tsf_framer: NCH must be 8 or 16");
	end

	function automatic logic [3:0] flen_log2(input logic [2:0] m);
		case (m)
			M_4X32:  return L2_128;
			M_8X32:  return L2_256;
			M_16X32: return L2_512;
			M_2X16:  return L2_32;
			default: return L2_64;
		endcase
	endfunction

	function automatic logic [3:0] slot_log2(input logic [2:0] m);
		return (m == M_4X16 || m == M_2X16) ? L2_16 : L2_32;
	endfunction

	function automatic logic [4:0] nslots(input logic [2:0] m);
		return 5'(5'h01 << (flen_log2(m) - slot_log2(m)));
	endfunction

	function automatic logic [5:0] wid_bits(input tsf_cfg_t c);
		if (slot_log2(c.mode) == L2_16)
			return WB_16;
		case (c.wid)
			W_16:    return WB_16;
			W_32:    return WB_32;
			default: return WB_24;
		endcase
	endfunction

	function automatic logic [4:0] dly_bits(input logic [1:0] d);
		case (d)
			D_0:     return DB_0;
			D_8:     return DB_8;
			D_16:    return DB_16;
			default: return DB_1;
		endcase
	endfunction

	function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
		return a[7:6] == base[7:6] && a[1:0] == 2'h0;
	endfunction

	// System side
	tsf_cfg_t    cfg_r;
	logic [31:0] tx_mem [NCH];
	logic [31:0] rx_mem [NCH];
	logic [31:0] rdata_r;
	logic [31:0] ack_word_r;
	logic        ack_tgl_r;
	logic [2:0]  ltog_s;
	logic [2:0]  ltog_seen_r;
	logic [7:0]  fcnt_r;
	logic        lock_r;
	logic [3:0]  widx;

	// Link side
	logic        lclk;
	logic        lrst_a_r;
	logic        lrst_r;
	tsf_cfg_t    lcfg;
	logic        ack_s;
	logic        ack_seen_r;
	logic        rx_tgl_r;
	logic        frm_tgl_r;
	logic        req_tgl_r;
	logic [3:0]  req_ch_r;
	logic [31:0] rx_word_r;
	logic [3:0]  rx_ch_r;

	assign widx = bus_addr[5:2];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_r <= CFG_RST;
		end else if (bus_wr && bus_addr == A_CTRL) begin
			cfg_r.mode  <= bus_wdata[F_MODE +: 3];
			cfg_r.dly   <= bus_wdata[F_DLY +: 2];
			cfg_r.wid   <= bus_wdata[F_WID +: 2];
			cfg_r.bpol  <= bus_wdata[F_BPOL];
			cfg_r.fpol  <= bus_wdata[F_FPOL];
			cfg_r.fwave <= bus_wdata[F_FWAVE];
			cfg_r.en    <= bus_wdata[F_EN];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++)
				tx_mem[i] <= '0;
		end else if (bus_wr && in_win(bus_addr, A_TX) && int'(widx) < NCH) begin
			tx_mem[widx] <= bus_wdata;
		end
	end

	// Read data stand for one cycle only; unmapped reads give zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (!bus_rd) begin
			rdata_r <= '0;
		end else if (bus_addr == A_CTRL) begin
			rdata_r <= '0;
			rdata_r[F_MODE +: 3] <= cfg_r.mode;
			rdata_r[F_DLY +: 2] <= cfg_r.dly;
			rdata_r[F_WID +: 2] <= cfg_r.wid;
			rdata_r[F_BPOL] <= cfg_r.bpol;
			rdata_r[F_FPOL] <= cfg_r.fpol;
			rdata_r[F_FWAVE] <= cfg_r.fwave;
			rdata_r[F_EN] <= cfg_r.en;
		end else if (bus_addr == A_STAT) begin
			rdata_r <= '0;
			rdata_r[S_LOCK] <= lock_r;
			rdata_r[S_FCNT +: 8] <= fcnt_r;
		end else if (in_win(bus_addr, A_TX) && int'(widx) < NCH) begin
			rdata_r <= tx_mem[widx];
		end else if (in_win(bus_addr, A_RX) && int'(widx) < NCH
				&& {1'b0, widx} < nslots(cfg_r.mode)) begin
			rdata_r <= rx_mem[widx];
		end else begin
			rdata_r <= '0;
		end
	end

	assign bus_rdata = rdata_r;

	// Link events: bit 0 word received, bit 1 frame seen, bit 2 word wanted
	tsf_sync #(.W(3)) u_to_sys (
		.clk (clk_sys),
		.rst (rst),
		.d   ({req_tgl_r, frm_tgl_r, rx_tgl_r}),
		.q   (ltog_s)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ltog_seen_r <= '0;
		end else begin
			ltog_seen_r <= ltog_s;
		end
	end

	// Link-side word holders change at most once per slot, long after this copy
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++)
				rx_mem[i] <= '0;
		end else if (ltog_s[0] != ltog_seen_r[0] && int'(rx_ch_r) < NCH) begin
			rx_mem[rx_ch_r] <= rx_word_r;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_word_r <= '0;
			ack_tgl_r  <= 1'b0;
		end else if (ltog_s[2] != ltog_seen_r[2]) begin
			ack_word_r <= (int'(req_ch_r) < NCH) ? tx_mem[req_ch_r] : '0;
			ack_tgl_r  <= ~ack_tgl_r;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fcnt_r <= '0;
			lock_r <= 1'b0;
		end else if (!cfg_r.en) begin
			lock_r <= 1'b0;
		end else if (ltog_s[1] != ltog_seen_r[1]) begin
			fcnt_r <= fcnt_r + 8'h01;
			lock_r <= 1'b1;
		end
	end

	// Link domain; polarity must only change while the port is disabled
	assign lclk = bit_clk ^ cfg_r.bpol;

	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			lrst_a_r <= 1'b1;
			lrst_r   <= 1'b1;
		end else begin
			lrst_a_r <= 1'b0;
			lrst_r   <= lrst_a_r;
		end
	end

	// Config is quasi-static, so a plain two-flop copy is enough
	tsf_sync #(.W($bits(tsf_cfg_t) + 1)) u_to_link (
		.clk (lclk),
		.rst (lrst_r),
		.d   ({ack_tgl_r, cfg_r}),
		.q   ({ack_s, lcfg})
	);

	logic [4:0]  dly;
	logic [5:0]  wid;
	logic [3:0]  sl2;
	logic [8:0]  fmask;
	logic [8:0]  smask;
	logic [8:0]  half;
	logic [3:0]  last_slot;
	logic        fc;
	logic        fc_q_r;
	logic        start;
	logic        mid;
	logic        locked_r;
	logic [8:0]  pos_r;
	logic [8:0]  pos_n;
	logic [8:0]  npos;
	logic [8:0]  cq;
	logic [8:0]  nq;
	logic [3:0]  cslot;
	logic [3:0]  nslot;
	logic [5:0]  crel;
	logic [5:0]  nrel;
	logic        cv;
	logic        nv;
	logic [31:0] tx_cur_r;
	logic [31:0] tx_next_r;
	logic        out_r;
	logic [31:0] rx_sh_r;
	logic [31:0] sh_n;

	assign dly       = dly_bits(lcfg.dly);
	assign wid       = wid_bits(lcfg);
	assign sl2       = slot_log2(lcfg.mode);
	assign fmask     = 9'((10'h001 << flen_log2(lcfg.mode)) - 10'h001);
	assign smask     = 9'((10'h001 << sl2) - 10'h001);
	assign half      = 9'((10'h001 << flen_log2(lcfg.mode)) >> 1);
	assign last_slot = 4'(nslots(lcfg.mode) - 5'h01);
	assign fc        = frame_clk ^ lcfg.fpol;
	assign start     = fc && !fc_q_r;
	// A level-style frame clock also marks the frame midpoint with its trailing edge
	assign mid       = lcfg.fwave && !fc && fc_q_r;

	always_comb begin
		if (start)
			pos_n = '0;
		else if (mid)
			pos_n = half;
		else
			pos_n = (pos_r + 9'h001) & fmask;
	end

	// Positions are taken modulo the frame, so a late word spills into the next frame
	assign npos  = (pos_n + 9'h001) & fmask;
	assign cq    = (pos_n - 9'(dly)) & fmask;
	assign nq    = (npos - 9'(dly)) & fmask;
	assign cslot = 4'(cq >> sl2);
	assign nslot = 4'(nq >> sl2);
	assign crel  = 6'(cq & smask);
	assign nrel  = 6'(nq & smask);
	assign cv    = locked_r && lcfg.en && crel < wid && int'(cslot) < NCH;
	assign nv    = locked_r && lcfg.en && nrel < wid && int'(nslot) < NCH;

	always_ff @(posedge lclk or posedge lrst_r) begin
		if (lrst_r) begin
			fc_q_r    <= 1'b0;
			pos_r     <= '0;
			locked_r  <= 1'b0;
			frm_tgl_r <= 1'b0;
		end else begin
			fc_q_r <= fc;
			pos_r  <= pos_n;
			if (!lcfg.en)
				locked_r <= 1'b0;
			else if (start)
				locked_r <= 1'b1;
			if (lcfg.en && start)
				frm_tgl_r <= ~frm_tgl_r;
		end
	end

	// Transmit: the output flop carries the bit of the next position
	always_ff @(posedge lclk or posedge lrst_r) begin
		if (lrst_r) begin
			tx_cur_r  <= '0;
			out_r     <= 1'b0;
			req_tgl_r <= 1'b0;
			req_ch_r  <= '0;
		end else begin
			if (nv && nrel == 6'h00) begin
				tx_cur_r  <= tx_next_r;
				req_ch_r  <= (nslot == last_slot) ? 4'h0 : nslot + 4'h1;
				req_tgl_r <= ~req_tgl_r;
			end
			if (!nv)
				out_r <= 1'b0;
			else if (nrel == 6'h00)
				out_r <= tx_next_r[31];
			else
				out_r <= tx_cur_r[5'(6'h1F - nrel)];
		end
	end

	assign data_out = out_r;

	always_ff @(posedge lclk or posedge lrst_r) begin
		if (lrst_r) begin
			tx_next_r  <= '0;
			ack_seen_r <= 1'b0;
		end else begin
			ack_seen_r <= ack_s;
			if (ack_s != ack_seen_r)
				tx_next_r <= ack_word_r;
		end
	end

	// Receive: words are left-justified, unused low bits zero
	always_comb begin
		sh_n = (crel == 6'h00) ? '0 : rx_sh_r;
		sh_n[5'(6'h1F - crel)] = data_in;
	end

	always_ff @(posedge lclk or posedge lrst_r) begin
		if (lrst_r) begin
			rx_sh_r   <= '0;
			rx_word_r <= '0;
			rx_ch_r   <= '0;
			rx_tgl_r  <= 1'b0;
		end else if (cv) begin
			rx_sh_r <= sh_n;
			if (crel == wid - 6'h01) begin
				rx_word_r <= sh_n;
				rx_ch_r   <= cslot;
				rx_tgl_r  <= ~rx_tgl_r;
			end
		end
	end

	logic nxt_msb;
	assign nxt_msb = tx_next_r[31];

	AST_LEN8: assert property (@(posedge lclk) disable iff (lrst_r)
		(start && locked_r && lcfg.mode == M_8X32) |-> pos_r == 9'h0FF && sl2 == L2_32)
		else $error("eight-slot frame length wrong");
	AST_LEN16: assert property (@(posedge lclk) disable iff (lrst_r)
		(start && locked_r && lcfg.mode == M_16X32) |-> pos_r == 9'h1FF)
		else $error("sixteen-slot frame did not wrap at 512");
	AST_LEN_SMALL: assert property (@(posedge lclk) disable iff (lrst_r)
		lcfg.mode == M_4X32 |-> fmask == 9'h07F && last_slot == 4'h3)
		else $error("four-slot frame length wrong");
	AST_W16: assert property (@(posedge lclk) disable iff (lrst_r)
		lcfg.mode == M_2X16 |-> wid == WB_16 && fmask == 9'h01F)
		else $error("two 16-clock slots mode wrong");
	AST_MSB_AT: assert property (@(posedge lclk) disable iff (lrst_r)
		(nv && nrel == 6'h00) |-> npos == (((9'(nslot) << sl2) + 9'(dly)) & fmask))
		else $error("word MSB not at slot delay");
	AST_IDLE_ZERO: assert property (@(posedge lclk) disable iff (lrst_r)
		!nv |=> !data_out)
		else $error("idle bit clock not driven zero");
	AST_MSB_FIRST: assert property (@(posedge lclk) disable iff (lrst_r)
		(nv && nrel == 6'h00) |=> data_out == $past(nxt_msb))
		else $error("word not sent MSB first");
	AST_WORD_DONE: assert property (@(posedge lclk) disable iff (lrst_r)
		(cv && crel == wid - 6'h01) |=> rx_tgl_r != $past(rx_tgl_r))
		else $error("received word not handed over");
	AST_SPILL: assert property (@(posedge lclk) disable iff (lrst_r)
		(locked_r && lcfg.en && lcfg.mode == M_8X32 && lcfg.wid == W_32
			&& lcfg.dly == D_16 && pos_n == 9'h000) |-> cv && cslot == 4'h7)
		else $error("spilled last word not received");
	AST_FSTART: assert property (@(posedge lclk) disable iff (lrst_r)
		$rose(fc) |=> pos_r == 9'h000)
		else $error("frame edge did not restart position");
	AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
		(bus_rd && in_win(bus_addr, A_RX) && {1'b0, widx} >= nslots(cfg_r.mode))
			|=> bus_rdata == 32'h0)
		else $error("unused channel did not read zero");

	COV_16CH_WORD: cover property (@(posedge lclk) disable iff (lrst_r)
		lcfg.mode == M_16X32 && cv && cslot == 4'hF && crel == wid - 6'h01);
	COV_SPILL: cover property (@(posedge lclk) disable iff (lrst_r)
		cv && pos_n < 9'(dly));
	COV_RX_READ: cover property (@(posedge clk_sys) disable iff (rst)
		bus_rd && in_win(bus_addr, A_RX) && lock_r);
endmodule // tsf_framer

/* shared/tsf_pkg.sv */
// Register map, field layout, encodings and config carrier of the TDM framer
package tsf_pkg;
	localparam int          ADDR_W  = 8;
	localparam logic [7:0]  A_CTRL  = 8'h00;
	localparam logic [7:0]  A_STAT  = 8'h04;
	localparam logic [7:0]  A_TX    = 8'h40;
	localparam logic [7:0]  A_RX    = 8'h80;
	// Control word fields
	localparam int          F_MODE  = 0;
	localparam int          F_DLY   = 3;
	localparam int          F_WID   = 5;
	localparam int          F_BPOL  = 7;
	localparam int          F_FPOL  = 8;
	localparam int          F_FWAVE = 9;
	localparam int          F_EN    = 16;
	// Status word fields
	localparam int          S_LOCK  = 0;
	localparam int          S_FCNT  = 8;
	// Slot-count modes
	localparam logic [2:0]  M_2X32  = 3'h0;
	localparam logic [2:0]  M_4X32  = 3'h1;
	localparam logic [2:0]  M_8X32  = 3'h2;
	localparam logic [2:0]  M_16X32 = 3'h3;
	localparam logic [2:0]  M_4X16  = 3'h4;
	localparam logic [2:0]  M_2X16  = 3'h5;
	// Log2 of frame and slot length in bit clocks
	localparam logic [3:0]  L2_32   = 4'h5;
	localparam logic [3:0]  L2_64   = 4'h6;
	localparam logic [3:0]  L2_128  = 4'h7;
	localparam logic [3:0]  L2_256  = 4'h8;
	localparam logic [3:0]  L2_512  = 4'h9;
	localparam logic [3:0]  L2_16   = 4'h4;
	// Sample width codes and their bit counts
	localparam logic [1:0]  W_24    = 2'h0;
	localparam logic [1:0]  W_16    = 2'h1;
	localparam logic [1:0]  W_32    = 2'h2;
	localparam logic [5:0]  WB_16   = 6'h10;
	localparam logic [5:0]  WB_24   = 6'h18;
	localparam logic [5:0]  WB_32   = 6'h20;
	// MSB delay codes and their bit-clock offsets
	localparam logic [1:0]  D_1     = 2'h0;
	localparam logic [1:0]  D_0     = 2'h1;
	localparam logic [1:0]  D_8     = 2'h2;
	localparam logic [1:0]  D_16    = 2'h3;
	localparam logic [4:0]  DB_0    = 5'h00;
	localparam logic [4:0]  DB_1    = 5'h01;
	localparam logic [4:0]  DB_8    = 5'h08;
	localparam logic [4:0]  DB_16   = 5'h10;

	typedef struct packed {
		logic       en;
		logic       fwave;
		logic       fpol;
		logic       bpol;
		logic [1:0] wid;
		logic [1:0] dly;
		logic [2:0] mode;
	} tsf_cfg_t;

	localparam tsf_cfg_t CFG_RST = '0;
endpackage

/* src/tsf_sync.sv */
// Two-flop level synchroniser, any width
`timescale 1ns/10ps
module tsf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;

	if (W < 1) begin : g_chk
		$error("tsf_sync: W must be positive");
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end

	assign q = s2_r;
endmodule // tsf_sync

/* dv/tsf_peer.sv */
// Behavioural TDM partner: bit and frame clock source, serial source and sink
`timescale 1ns/10ps
module tsf_peer (
	output logic      bit_clk,
	output logic      frame_clk,
	output logic      data_in,
	input  wire logic data_out,
	input  wire logic run,
	input  wire logic bpol,
	input  wire logic fpol,
	input  wire logic fwave,
	input  var  int   flen,
	input  var  int   sl,
	input  var  int   dly,
	input  var  int   wb,
	input  var  int   ns,
	input  var  int   salt
);
	logic        clk_raw = 1'b0;
	logic        fc = 1'b0;
	int          pos = -1;
	int          idle_err = 0;
	logic [31:0] cap [16];

	function automatic logic [31:0] src_word(input int ch);
		return 32'h9C3B5E71 + ch * 32'h0F1E2D3C + salt * 32'h01030507;
	endfunction

	// Late words wrap modulo the frame, so spilled bits land at the next frame start;
	// this partner tolerates frame-crossing words, which real partners may not
	function automatic bit locate(input int p, output int ch, output int i);
		for (int c = 0; c < ns; c++) begin
			i = ((p - c * sl - dly) % flen + flen) % flen;
			ch = c;
			if (i < wb) return 1'b1;
		end
		return 1'b0;
	endfunction

	// Clock stands still while stopped; its phase is unrelated to clk_sys
	always #24 if (run) clk_raw = ~clk_raw;
	assign bit_clk   = clk_raw ^ bpol;
	assign frame_clk = fc ^ fpol;
	// Each stop or start forgets the captures of the previous format
	always @(run) begin : restart
		pos = -1;
		for (int c = 0; c < 16; c++) cap[c] = '0;
	end

	always @(negedge clk_raw) begin : drive
		int          ch;
		int          i;
		logic [31:0] w;
		pos = (pos + 1 >= flen) ? 0 : pos + 1;
		fc = fwave ? (pos < flen / 2) : (pos == 0);
		data_in = 1'b0;
		if (locate(pos, ch, i)) begin
			w = src_word(ch);
			data_in = w[31 - i];
		end
	end

	always @(posedge clk_raw) begin : sink
		int ch;
		int i;
		if (pos >= 0) begin
			if (locate(pos, ch, i)) cap[ch][31 - i] = data_out;
			else if (data_out !== 1'b0) idle_err++;
		end
	end
endmodule // tsf_peer

/* dv/tsf_framer_tb_top.sv */
// Self-checking bench of the TDM framer: register tasks and slot format sweeps
`timescale 1ns/10ps
module tsf_framer_tb_top;
	import tsf_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [31:0] bus_rdata;
	logic        bit_clk;
	logic        frame_clk;
	logic        data_in;
	logic        data_out;
	// Partner clock stays still until the first format is set up
	logic        run = 1'b0;
	logic        bpol = 1'b0;
	logic        fpol = 1'b0;
	logic        fwave = 1'b0;
	int          flen = 64;
	int          sl = 32;
	int          dly = 1;
	int          wb = 24;
	int          ns = 2;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          seq = 0;
	logic [31:0] got;
	logic [10:0] tbl [5] = '{11'h001, 11'h0DA, 11'h013, 11'h054, 11'h38D};

	tsf_framer #(.NCH(16)) dut (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.bit_clk(bit_clk), .frame_clk(frame_clk), .data_in(data_in), .data_out(data_out));
	tsf_peer peer (.bit_clk(bit_clk), .frame_clk(frame_clk), .data_in(data_in),
		.data_out(data_out), .run(run), .bpol(bpol), .fpol(fpol), .fwave(fwave),
		.flen(flen), .sl(sl), .dly(dly), .wb(wb), .ns(ns), .salt(seq));

	always #50 clk_sys = ~clk_sys;

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Ceiling well above the longest sweep so a stuck link ends the run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		@(negedge clk_sys);
		d = bus_rdata;
	endtask

	function automatic logic [31:0] tx_pat(input int ch);
		return 32'h5AC31E87 + ch * 32'h10204081 + seq * 32'h01010101;
	endfunction

	// Clears only the enable, so the link clock keeps its polarity while the port stops
	task automatic stop_port();
		logic [31:0] v;
		rd(A_CTRL, v);
		wr(A_CTRL, v & ~(32'h1 << F_EN));
		repeat (20) @(posedge clk_sys);
	endtask

	task automatic run_cfg(input tsf_cfg_t c);
		int          e0;
		logic [31:0] m;
		logic [31:0] v;
		// Disable first, then freeze the partner before either side's polarity moves
		stop_port();
		run <= 1'b0;
		repeat (2) @(posedge clk_sys);
		case (c.mode)
			M_4X32, M_4X16: ns <= 4;
			M_8X32: ns <= 8;
			M_16X32: ns <= 16;
			default: ns <= 2;
		endcase
		sl <= (c.mode == M_4X16 || c.mode == M_2X16) ? 16 : 32;
		wb <= (c.mode == M_4X16 || c.mode == M_2X16 || c.wid == W_16) ? 16 :
			(c.wid == W_32) ? 32 : 24;
		dly <= (c.dly == D_0) ? 0 : (c.dly == D_1) ? 1 : (c.dly == D_8) ? 8 : 16;
		{fwave, fpol} <= {c.fwave, c.fpol};
		seq <= seq + 1;
		@(posedge clk_sys);
		flen <= ns * sl;
		// Bit clock polarity moves a cycle after the frame clock, never in one time step
		bpol <= c.bpol;
		wr(A_CTRL, {22'h0, c[9:0]});
		for (int ch = 0; ch < ns; ch++) wr(A_TX + 8'(4 * ch), tx_pat(ch));
		e0 = peer.idle_err;
		run <= 1'b1;
		wr(A_CTRL, {15'h0, 1'b1, 6'h0, c[9:0]});
		repeat (flen * 3) @(posedge clk_sys);
		m = 32'hFFFFFFFF << (32 - wb);
		for (int ch = 0; ch < ns; ch++) begin
			rd(A_RX + 8'(4 * ch), v);
			chk(v, peer.src_word(ch) & m);
			chk(peer.cap[ch] & m, tx_pat(ch) & m);
		end
		if (ns < 16) begin
			rd(A_RX + 8'(4 * ns), v);
			chk(v, 32'h0);
		end
		rd(A_STAT, v);
		chk({31'h0, v[S_LOCK]}, 32'h1);
		chk(32'(peer.idle_err - e0), 32'h0);
		$display("Test mode %0d wid %0d dly %0d done", c.mode, c.wid, c.dly);
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(A_CTRL, got);
		chk(got, 32'h0);
		rd(A_STAT, got);
		chk(got, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20, got);
		chk(got, 32'h0);
		rd(8'h01, got);
		chk(got, 32'h0);
		wr(A_CTRL, 32'h000003FF);
		rd(A_CTRL, got);
		chk(got, 32'h000003FF);
		$display("Test registers done");
		// Every width and delay pairing, including the spilling 32-bit ones
		for (int w = 0; w < 3; w++) begin
			for (int d = 0; d < 4; d++) begin
				run_cfg(tsf_cfg_t'({4'h0, 2'(w), 2'(d), M_2X32}));
			end
		end
		for (int k = 0; k < 5; k++) run_cfg(tsf_cfg_t'(tbl[k]));
		stop_port();
		rd(A_STAT, got);
		chk({31'h0, got[S_LOCK]}, 32'h0);
		$display("Test disable done");
		finish_test();
	end
endmodule // tsf_framer_tb_top
